// >>> hw/smc_regs.v
// Motion sensor upper register bank behind a two-wire serial port
`include "smc_defs.vh"
module smc_regs #(
  parameter [7:0] REV_ID     = 8'h5A,  // Arbitrary revision value
  parameter       FIFO_DEPTH = 8,
  parameter       FIFO_AW    = 3
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       nrst,
  // Two-wire serial port; data pin split, enable low while driving
  input  wire       sclk,
  input  wire       sdio_in,
  output reg        sdio_out_ff,
  output reg        sdio_oe_n_ff,
  // Motion source from the tracking core
  input  wire       move_valid,
  input  wire [7:0] move_dx,
  input  wire [7:0] move_dy,
  output reg        move_ready_ff,
  // Device outputs
  output reg        motion_pin_ff,
  output reg        emitter_off_ff,
  output reg  [1:0] power_state_ff
);
  // Link FSM states
  localparam ST_CMD  = 2'b00;
  localparam ST_WR   = 2'b01;
  localparam ST_RD   = 2'b10;
  localparam ST_BRST = 2'b11;
  localparam PW      = 3;
  localparam          PULSE_CYC  = `SMC_PULSE_CYC;
  localparam          GAP_CYC    = `SMC_PULSE_GAP;
  localparam [PW-1:0] PULSE_LOAD = PULSE_CYC[PW-1:0];
  localparam [PW-1:0] PULSE_GAP  = GAP_CYC[PW-1:0];
  localparam [7:0]    PWR_RST    = `SMC_RST_POWER_STATE;

  reg  [2:0] sclk_sync_ff;
  reg  [1:0] sdio_sync_ff;
  reg  [1:0] st_ff;
  reg  [3:0] bit_cnt_ff;
  reg  [7:0] shift_ff;
  reg  [6:0] addr_ff;
  reg  [6:0] burst_addr_ff;
  reg  [7:0] emitter_ctrl_ff;
  reg  [7:0] pin_cfg_ff;
  reg  [7:0] burst_start_ff;
  reg  [7:0] burst_end_ff;
  reg  [7:0] delta_x_ff;
  reg  [7:0] delta_y_ff;
  reg        pending_ff;
  reg  [1:0] read_step_ff;
  reg  [PW-1:0] pulse_cnt_ff;
  reg        wr_strobe_ff;
  reg        rd_done_ff;
  reg  [6:0] rd_done_addr_ff;
  reg  [7:0] rd_data;
  reg  [6:0] rd_addr;
  reg  [7:0] nxt_emitter_ctrl;
  reg  [7:0] nxt_pin_cfg;
  reg  [7:0] nxt_burst_start;
  reg  [7:0] nxt_burst_end;
  reg  [1:0] nxt_power_state;
  reg  [7:0] nxt_delta_x;
  reg  [7:0] nxt_delta_y;
  reg        nxt_pending;
  reg  [1:0] nxt_read_step;
  reg  [PW-1:0] nxt_pulse_cnt;
  reg        nxt_motion_pin;
  wire       sclk_rise;
  wire       sclk_fall;
  wire       sdio_s;
  wire       fifo_valid;
  wire       fifo_ready;
  wire [15:0] fifo_data;
  wire       take_motion;
  wire       edge_mode;
  wire       polarity;
  wire       active_level;
  wire       idle_level;

  // Sample the link clock through three flops and the data pin through two
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sclk_sync_ff <= 3'h7;
      sdio_sync_ff <= 2'h0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[1:0], sclk};
      sdio_sync_ff <= {sdio_sync_ff[0], sdio_in};
    end
  end

  // Edges look only at the second and third stages
  assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
  assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
  assign sdio_s    = sdio_sync_ff[1];

  // Motion events queue here so bursts of frames are not lost while the pin is busy
  smc_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .in_valid  (move_valid),
    .in_ready  (fifo_ready),
    .in_data   ({move_dx, move_dy}),
    .out_valid (fifo_valid),
    .out_ready (take_motion),
    .out_data  (fifo_data),
    .flush     (1'b0)
  );

  assign edge_mode    = pin_cfg_ff[`SMC_BIT_EDGE_SEL];
  assign polarity     = pin_cfg_ff[`SMC_BIT_POLARITY];
  assign active_level = polarity;
  assign idle_level   = ~polarity;
  // Accumulate only when the host is not mid-readout, keeping X and Y coherent
  assign take_motion  = fifo_valid & (read_step_ff == 2'h0) & (pulse_cnt_ff == {PW{1'b0}});

  // Read mux, reserved bits read zero
  always @* begin
    rd_addr = (st_ff == ST_BRST) ? burst_addr_ff : addr_ff;
    case (rd_addr)
      `SMC_ADDR_REV_ID:       rd_data = REV_ID;
      `SMC_ADDR_MOVE_STATUS:  rd_data = {pending_ff, 7'h00};
      `SMC_ADDR_DELTA_X:      rd_data = delta_x_ff;
      `SMC_ADDR_DELTA_Y:      rd_data = delta_y_ff;
      `SMC_ADDR_INV_REV:      rd_data = ~REV_ID;
      `SMC_ADDR_EMITTER_CTRL: rd_data = emitter_ctrl_ff;
      `SMC_ADDR_MOVE_PIN_CFG: rd_data = pin_cfg_ff;
      `SMC_ADDR_BURST_START:  rd_data = burst_start_ff;
      `SMC_ADDR_BURST_END:    rd_data = burst_end_ff;
      `SMC_ADDR_POWER_STATE:  rd_data = {power_state_ff, 6'h00};
      `SMC_ADDR_BURST_TRIG:   rd_data = `SMC_RST_BURST_TRIG;
      default:                rd_data = 8'h00;
    endcase
  end

  // Serial link: address byte with write flag on top, then one data byte or a burst
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_ff           <= ST_CMD;
      bit_cnt_ff      <= 4'h0;
      shift_ff        <= 8'h00;
      addr_ff         <= 7'h00;
      burst_addr_ff   <= 7'h00;
      sdio_out_ff     <= 1'b0;
      sdio_oe_n_ff    <= 1'b1;
      wr_strobe_ff    <= 1'b0;
      rd_done_ff      <= 1'b0;
      rd_done_addr_ff <= 7'h00;
    end else begin
      wr_strobe_ff <= 1'b0;
      rd_done_ff   <= 1'b0;
      case (st_ff)
        ST_CMD: begin
          sdio_oe_n_ff <= 1'b1;
          if (sclk_rise) begin
            shift_ff   <= {shift_ff[6:0], sdio_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == 4'h7) begin
              bit_cnt_ff    <= 4'h0;
              addr_ff       <= {shift_ff[5:0], sdio_s};
              burst_addr_ff <= burst_start_ff[6:0];
              if (shift_ff[6]) begin
                st_ff <= ST_WR;
              end else if ({shift_ff[5:0], sdio_s} == `SMC_ADDR_BURST_TRIG) begin
                st_ff <= ST_BRST;
              end else begin
                st_ff <= ST_RD;
              end
            end
          end
        end
        ST_WR: begin
          if (sclk_rise) begin
            shift_ff   <= {shift_ff[6:0], sdio_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == 4'h7) begin
              bit_cnt_ff   <= 4'h0;
              shift_ff     <= {shift_ff[6:0], sdio_s};
              wr_strobe_ff <= 1'b1;
              st_ff        <= ST_CMD;
            end
          end
        end
        ST_RD, ST_BRST: begin
          // Data changes on falling edges so the host samples on rising ones
          if (sclk_fall) begin
            sdio_oe_n_ff <= 1'b0;
            sdio_out_ff  <= rd_data[3'h7 - bit_cnt_ff[2:0]];
          end
          if (sclk_rise && !sdio_oe_n_ff) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == 4'h7) begin
              bit_cnt_ff      <= 4'h0;
              rd_done_ff      <= 1'b1;
              rd_done_addr_ff <= rd_addr;
              // Burst walks start..end; host must clock exactly that many bytes
              if (st_ff == ST_BRST && burst_addr_ff != burst_end_ff[6:0]) begin
                burst_addr_ff <= burst_addr_ff + 7'h01;
              end else begin
                st_ff <= ST_CMD;
              end
            end
          end
        end
        default: st_ff <= ST_CMD;
      endcase
    end
  end

  // Next configuration values; reserved bits masked off on the way in
  always @* begin
    nxt_emitter_ctrl = emitter_ctrl_ff;
    nxt_pin_cfg      = pin_cfg_ff;
    nxt_burst_start  = burst_start_ff;
    nxt_burst_end    = burst_end_ff;
    nxt_power_state  = power_state_ff;
    if (wr_strobe_ff) begin
      case (addr_ff)
        `SMC_ADDR_EMITTER_CTRL: nxt_emitter_ctrl = shift_ff & `SMC_MASK_EMITTER;
        `SMC_ADDR_MOVE_PIN_CFG: nxt_pin_cfg      = shift_ff & `SMC_MASK_PIN_CFG;
        `SMC_ADDR_BURST_START:  nxt_burst_start  = shift_ff;
        `SMC_ADDR_BURST_END:    nxt_burst_end    = shift_ff;
        `SMC_ADDR_POWER_STATE:  nxt_power_state  = shift_ff[7:6];
        default:                nxt_power_state  = power_state_ff;
      endcase
    end
  end

  // Configuration registers; unmapped writes leave them untouched
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      emitter_ctrl_ff <= `SMC_RST_EMITTER_CTRL;
      pin_cfg_ff      <= `SMC_RST_MOVE_PIN_CFG;
      burst_start_ff  <= `SMC_RST_BURST_START;
      burst_end_ff    <= `SMC_RST_BURST_END;
      power_state_ff  <= PWR_RST[7:6];
    end else begin
      emitter_ctrl_ff <= nxt_emitter_ctrl;
      pin_cfg_ff      <= nxt_pin_cfg;
      burst_start_ff  <= nxt_burst_start;
      burst_end_ff    <= nxt_burst_end;
      power_state_ff  <= nxt_power_state;
    end
  end

  // Emitter force-off follows bit 3, registered
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      emitter_off_ff <= 1'b0;
    end else begin
      emitter_off_ff <= emitter_ctrl_ff[`SMC_BIT_FORCE_OFF];
    end
  end

  // Next displacement and readout step; a finished read is never lost to motion
  always @* begin
    nxt_delta_x   = delta_x_ff;
    nxt_delta_y   = delta_y_ff;
    nxt_pending   = pending_ff;
    nxt_read_step = read_step_ff;
    // Status then X then Y; Y completes the readout
    if (rd_done_ff) begin
      if (rd_done_addr_ff == `SMC_ADDR_MOVE_STATUS) begin
        nxt_read_step = 2'h1;
      end else if (rd_done_addr_ff == `SMC_ADDR_DELTA_X && read_step_ff == 2'h1) begin
        nxt_read_step = 2'h2;
      end else if (rd_done_addr_ff == `SMC_ADDR_DELTA_Y && read_step_ff == 2'h2) begin
        nxt_read_step = 2'h0;
        nxt_delta_x   = 8'h00;
        nxt_delta_y   = 8'h00;
        nxt_pending   = 1'b0;
      end
    end
    // Motion wins over the clear, though the step gate keeps them apart
    if (take_motion) begin
      nxt_delta_x = delta_x_ff + fifo_data[15:8];
      nxt_delta_y = delta_y_ff + fifo_data[7:0];
      nxt_pending = 1'b1;
    end
  end

  // Displacement registers and readout step
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      delta_x_ff   <= 8'h00;
      delta_y_ff   <= 8'h00;
      pending_ff   <= 1'b0;
      read_step_ff <= 2'h0;
    end else begin
      delta_x_ff   <= nxt_delta_x;
      delta_y_ff   <= nxt_delta_y;
      pending_ff   <= nxt_pending;
      read_step_ff <= nxt_read_step;
    end
  end

  // Motion pin: level while pending, or a fixed pulse per event
  always @* begin
    nxt_pulse_cnt = pulse_cnt_ff;
    if (take_motion && edge_mode) begin
      nxt_pulse_cnt = PULSE_LOAD;
    end else if (pulse_cnt_ff != {PW{1'b0}}) begin
      nxt_pulse_cnt = pulse_cnt_ff - 1'b1;
    end
    if (edge_mode) begin
      // Four active cycles, then one idle so back-to-back events stay separate edges
      nxt_motion_pin = (take_motion || pulse_cnt_ff > PULSE_GAP) ? active_level : idle_level;
    end else begin
      nxt_motion_pin = (pending_ff || take_motion) ? active_level : idle_level;
    end
  end

  // Pin, pulse counter and buffer-ready copy
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pulse_cnt_ff  <= {PW{1'b0}};
      motion_pin_ff <= 1'b1;
      move_ready_ff <= 1'b0;
    end else begin
      pulse_cnt_ff  <= nxt_pulse_cnt;
      motion_pin_ff <= nxt_motion_pin;
      move_ready_ff <= fifo_ready;
    end
  end
endmodule

// >>> hw/smc_defs.vh
// Constants for the motion sensor upper register bank
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH
`define SMC_ADDR_REV_ID        7'h01
`define SMC_ADDR_MOVE_STATUS   7'h02
`define SMC_ADDR_DELTA_X       7'h03
`define SMC_ADDR_DELTA_Y       7'h04
`define SMC_ADDR_INV_REV       7'h3F
`define SMC_ADDR_EMITTER_CTRL  7'h40
`define SMC_ADDR_MOVE_PIN_CFG  7'h41
`define SMC_ADDR_BURST_START   7'h42
`define SMC_ADDR_BURST_END     7'h44
`define SMC_ADDR_POWER_STATE   7'h45
`define SMC_ADDR_BURST_TRIG    7'h63
`define SMC_RST_EMITTER_CTRL   8'h00
`define SMC_RST_MOVE_PIN_CFG   8'h40
`define SMC_RST_BURST_START    8'h03
`define SMC_RST_BURST_END      8'h09
`define SMC_RST_POWER_STATE    8'h00
`define SMC_RST_BURST_TRIG     8'h00
`define SMC_BIT_FORCE_OFF      3
`define SMC_BIT_EDGE_SEL       6
`define SMC_BIT_POLARITY       7
`define SMC_MASK_EMITTER       8'h08
`define SMC_MASK_PIN_CFG       8'hC0
`define SMC_MASK_POWER         8'hC0
`define SMC_BIT_MOVE_FLAG      7
`define SMC_PULSE_NS           380
`define SMC_CLK_NS             100
`define SMC_PULSE_CYC          ((`SMC_PULSE_NS + `SMC_CLK_NS - 1) / `SMC_CLK_NS)
`define SMC_PULSE_GAP          1
`define SMC_CMD_BITS           8
`define SMC_DATA_BITS          8
`endif

// >>> hw/smc_fifo.v
// Small synchronous FIFO with valid and ready on both sides
module smc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             nrst,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  // Flush
  input  wire             flush
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;

  // Full and empty come straight from the count
  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data  = mem_ff[rd_ptr_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage has no reset, only pointers and count do
  always @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and count
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// >>> verif/smc_regs_sva.sv
// Port assertions for the motion sensor register bank
module smc_regs_sva (
  // Clock and reset
  input wire       clk_sys,
  input wire       nrst,
  // Link
  input wire       sclk,
  input wire       sdio_out_ff,
  input wire       sdio_oe_n_ff,
  // Device outputs
  input wire       move_ready_ff,
  input wire       motion_pin_ff,
  input wire       emitter_off_ff,
  input wire [1:0] power_state_ff
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // Outputs leave reset inactive
  a_reset_out: assert property ($rose(nrst) |-> motion_pin_ff && !emitter_off_ff && power_state_ff == 2'b00)
    else $error("outputs not at reset values");
  a_ready_up: assert property ($rose(nrst) |-> ##[0:2] move_ready_ff)
    else $error("buffer not ready after reset");
  // Pin taken and data moved only after a falling link edge
  a_drive_low: assert property ($fell(sdio_oe_n_ff) |-> !$past(sclk, 2))
    else $error("data pin taken during clock high");
  a_data_fall: assert property (!sdio_oe_n_ff && $changed(sdio_out_ff) |-> !$past(sclk, 2))
    else $error("read data moved away from a falling edge");
  a_release_high: assert property ($rose(sdio_oe_n_ff) |-> sclk)
    else $error("data pin released with clock low");
  // Pulses are four cycles; a level run outlasts any pulse
  a_pulse_len: assert property ($changed(motion_pin_ff) ##1 $stable(motion_pin_ff)[*4] |=> $stable(motion_pin_ff)[*4])
    else $error("motion pin run between pulse and level length");
  // Config outputs move only as a write frame closes
  a_power_end: assert property ($changed(power_state_ff) |-> sclk && $past(sclk, 2))
    else $error("power state moved inside a frame");
  a_emit_end: assert property ($changed(emitter_off_ff) |-> sclk && $past(sclk, 2))
    else $error("emitter control moved inside a frame");
endmodule

bind smc_regs smc_regs_sva u_sva (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .sdio_out_ff(sdio_out_ff),
  .sdio_oe_n_ff(sdio_oe_n_ff), .move_ready_ff(move_ready_ff), .motion_pin_ff(motion_pin_ff),
  .emitter_off_ff(emitter_off_ff), .power_state_ff(power_state_ff));

// >>> verif/smc_host_model.sv
// Mouse controller model on the two-wire link
module smc_host_model (
  // Device side of the data pin
  input  wire logic sdio_out_ff,
  input  wire logic sdio_oe_n_ff,
  // Link pins
  output logic      sclk,
  output wire logic sdio_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       hb = 1'b1;
  logic       hdrv = 1'b1;
  logic [7:0] rq[$];
  // Undriven pin shows the inverse, never a stale copy
  assign sdio_in = !sdio_oe_n_ff ? sdio_out_ff : (hdrv ? hb : ~hb);
  initial sclk = 1'b1;
  // Byte out MSB first, changed while clock low
  task put(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      hdrv = 1'b1;
      hb = v[i];
      #400;
      sclk = 1'b1;
      #400;
    end
  endtask
  // Byte in, sampled on the rising edge
  task get(output logic [7:0] v);
    hdrv = 1'b0;
    for (int i = 0; i < 8; i++) begin
      sclk = 1'b0;
      #400;
      sclk = 1'b1;
      v = {v[6:0], sdio_in};
      #400;
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    put({1'b1, a});
    put(d);
    #1200;
  endtask
  // Caller gives the exact burst length
  task rd(input logic [6:0] a, input int n);
    logic [7:0] v;
    put({1'b0, a});
    repeat (n) begin
      get(v);
      rq.push_back(v);
    end
    #1200;
  endtask
endmodule

// >>> verif/tb_smc_regs.sv
// Self-checking bench for the motion sensor register bank
module tb_smc_regs;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] REV = 8'hA6;  // Arbitrary value
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic       move_valid = 1'b0;
  logic [7:0] move_dx = 8'h00;
  logic [7:0] move_dy = 8'h00;
  wire        sclk, sdio_in, sdio_out_ff, sdio_oe_n_ff, move_ready_ff, motion_pin_ff, emitter_off_ff;
  wire  [1:0] power_state_ff;
  int         n_fail = 0;
  int         cmp_count = 0;
  int         n;
  logic [31:0] seed = 32'd95240;
  logic [7:0] mdl [0:127];
  logic [7:0] b, rev, ax, ay;
  logic [6:0] regs [7] = '{7'h40, 7'h41, 7'h42, 7'h44, 7'h45, 7'h43, 7'h50};
  logic [7:0] pwr [4] = '{8'h40, 8'h80, 8'hC0, 8'h00};

  smc_regs #(.REV_ID(REV)) dut (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .sdio_in(sdio_in),
    .sdio_out_ff(sdio_out_ff), .sdio_oe_n_ff(sdio_oe_n_ff), .move_valid(move_valid), .move_dx(move_dx),
    .move_dy(move_dy), .move_ready_ff(move_ready_ff), .motion_pin_ff(motion_pin_ff),
    .emitter_off_ff(emitter_off_ff), .power_state_ff(power_state_ff));
  smc_host_model host (.sdio_out_ff(sdio_out_ff), .sdio_oe_n_ff(sdio_oe_n_ff), .sclk(sclk), .sdio_in(sdio_in));

  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function logic [7:0] msk(input logic [6:0] a);
    case (a)
      7'h40: return 8'h08;
      7'h41, 7'h45: return 8'hC0;
      7'h42, 7'h44: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude();
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Link activity starts just off a clock edge, never on it
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #20;
    host.wr(a, d);
    mdl[a] = d & msk(a);
  endtask
  task rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #20;
    host.rd(a, 1);
    d = host.rq.pop_front();
  endtask
  task rchk(input logic [6:0] a);
    rd(a, b);
    chk(b, mdl[a]);
  endtask
  // One event, held for a single cycle without waiting for the buffer to be ready
  task push(input logic [7:0] dx, input logic [7:0] dy);
    @(posedge clk_sys);
    move_valid <= 1'b1;
    move_dx <= dx;
    move_dy <= dy;
    @(posedge clk_sys);
    move_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ax = ax + dx;
    ay = ay + dy;
  endtask
  // Status, X, then Y: the order that releases the data
  task readout(input logic pend);
    rd(7'h02, b);
    chk(b & 8'h80, {pend, 7'h00});
    rd(7'h03, b);
    chk(b, ax);
    rd(7'h04, b);
    chk(b, ay);
    ax = 8'h00;
    ay = 8'h00;
  endtask
  task pulse(input logic act);
    n = 0;
    fork
      push(rnd() | 8'h01, rnd());
      repeat (30) begin
        @(posedge clk_sys);
        n += (motion_pin_ff === act);
      end
    join
    chk(n[7:0], 8'd4);
    readout(1'b1);
  endtask
  task level(input logic act);
    push(rnd() | 8'h01, rnd());
    n = 0;
    while (motion_pin_ff !== act && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    chk({7'h00, n >= 50}, 8'h00);
    repeat (20) @(posedge clk_sys);
    chk({7'h00, motion_pin_ff}, {7'h00, act});
    readout(1'b1);
    chk({7'h00, motion_pin_ff}, {7'h00, ~act});
  endtask

  initial forever #50 clk_sys = ~clk_sys;
  // Guard against a hung run
  initial begin
    #5ms;
    chk(8'hFF, 8'h00);
    conclude();
  end
  initial begin
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[7'h41] = 8'h40;
    mdl[7'h42] = 8'h03;
    mdl[7'h44] = 8'h09;
    ax = 8'h00;
    ay = 8'h00;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({motion_pin_ff, emitter_off_ff, power_state_ff, move_ready_ff, 3'b000}, 8'h88);
    foreach (regs[i]) rchk(regs[i]);
    rd(7'h01, rev);
    rd(7'h3F, b);
    chk(rev, REV);
    chk(b, ~REV);
    for (int i = 0; i < 2; i++) begin
      wr(7'h40, i ? (rnd() & 8'hF7) : (rnd() | 8'h08));
      rchk(7'h40);
      chk({7'h00, emitter_off_ff}, {7'h00, mdl[7'h40][3]});
    end
    foreach (pwr[i]) begin
      wr(7'h45, pwr[i] | (rnd() & 8'h3F));
      rchk(7'h45);
      chk({6'h00, power_state_ff}, {6'h00, pwr[i][7:6]});
    end
    pulse(1'b0);
    wr(7'h41, 8'hC0 | (rnd() & 8'h3F));
    rchk(7'h41);
    pulse(1'b1);
    readout(1'b0);
    wr(7'h41, 8'h00);
    level(1'b0);
    wr(7'h41, 8'h80);
    level(1'b1);
    // Burst across a hole in the map
    wr(7'h42, 8'h40);
    wr(7'h44, 8'h45);
    @(posedge clk_sys);
    #20;
    host.rd(7'h63, 6);
    for (int a = 8'h40; a <= 8'h45; a++) chk(host.rq.pop_front(), mdl[a]);
    // Hold a readout open so motion backs up into the buffer
    wr(7'h41, 8'h40);
    push(8'h03, 8'h05);
    rd(7'h02, b);
    n = 0;
    while (move_ready_ff === 1'b1 && n < 12) begin
      push(8'h11, 8'h22);
      n++;
    end
    chk(n[7:0], 8'd8);
    rd(7'h03, b);
    chk(b, 8'h03);
    rd(7'h04, b);
    chk(b, 8'h05);
    ax = 8'h88;
    ay = 8'h10;
    readout(1'b1);
    readout(1'b0);
    conclude();
  end
endmodule
